// ===== core/pmw_pkg.sv
// shared constants and types of the mode and wake control block
`default_nettype none
package pmw_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int AW = 4;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_MACLO = 4'h8;
	localparam logic [3:0] OFS_MACHI = 4'hc;
	localparam int CB_LLB = 0;
	localparam int CB_RLB = 1;
	localparam int CB_SPD = 2;
	localparam int CB_EDS = 3;
	localparam int CB_ANE = 4;
	localparam int CB_MAG = 5;
	localparam logic [5:0] CTRL_RST = 6'h10;
	localparam logic [31:0] MACLO_RST = 32'h0000_0000;
	localparam logic [15:0] MACHI_RST = 16'h0000;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// ----------------------------------------
	// straps, speeds, timing
	// ----------------------------------------
	localparam logic [3:0] MODE_NORMAL = 4'h1;
	localparam logic [3:0] MODE_TEST = 4'h4;
	localparam logic [3:0] MODE_CPD = 4'h7;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	localparam int CLK_NS = 100;
	localparam int BLINK_NS = 50_000_000;
	localparam int BLINK_CYC_DEF = (BLINK_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------
	// magic pattern
	// ----------------------------------------
	localparam logic [7:0] SYNC_BYTE = 8'hff;
	localparam int SYNC_BYTES = 6;
	localparam int ADDR_REPS = 16;
	localparam int MAC_BYTES = 6;
	typedef enum logic {MG_SYNC, MG_ADDR} pmw_mg_t;
endpackage
`default_nettype wire

// ===== core/pmw_rx_if.sv
// received byte stream handed to the magic packet detector
`default_nettype none
interface pmw_rx_if;
	logic byte_vld;
	logic [7:0] data;
	logic frame_end;
	logic frame_err;
	modport src(output byte_vld, data, frame_end, frame_err);
	modport dst(input byte_vld, data, frame_end, frame_err);
endinterface
`default_nettype wire

// ===== core/pmw_lamp.sv
// link and activity lamp encoder
`default_nettype none
module pmw_lamp import pmw_pkg::*; #(
	parameter int BLINK_CYC = BLINK_CYC_DEF
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// status
	input wire logic tri_mode,
	input wire logic link_up,
	input wire logic [1:0] link_speed,
	input wire logic activity,
	// lamps, low is lit
	output logic gig_link_lamp,
	output logic fast_link_lamp
);
	localparam int BW = $clog2(2 * BLINK_CYC + 1);
	logic [BW-1:0] bcnt_r, bcnt_nxt, acnt_r, acnt_nxt;
	logic tog_r, tog_nxt, gig_r, gig_nxt, fast_r, fast_nxt;
	logic lit, g_spd, f_spd;

	always_comb begin
		bcnt_nxt = bcnt_r + 1'b1;
		tog_nxt = tog_r;
		if (bcnt_r == BW'(BLINK_CYC - 1)) begin
			bcnt_nxt = '0;
			tog_nxt = !tog_r;
		end
		// each frame restarts the hold-off so bursts blink steadily
		acnt_nxt = (acnt_r != '0) ? acnt_r - 1'b1 : '0;
		if (activity) begin
			acnt_nxt = BW'(2 * BLINK_CYC);
		end
		lit = (acnt_r != '0) ? tog_r : 1'b1;
		g_spd = link_speed == SPD_1000 || link_speed == SPD_10;
		f_spd = link_speed == SPD_100 || link_speed == SPD_10;
		if (tri_mode) begin
			gig_nxt = !(link_up && g_spd && lit);
			fast_nxt = !(link_up && f_spd && lit);
		end else begin
			gig_nxt = !link_up;
			fast_nxt = !(link_up && acnt_r != '0 && tog_r);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bcnt_r <= '0;
			acnt_r <= '0;
			tog_r <= 1'b0;
			gig_r <= 1'b1;
			fast_r <= 1'b1;
		end else begin
			bcnt_r <= bcnt_nxt;
			acnt_r <= acnt_nxt;
			tog_r <= tog_nxt;
			gig_r <= gig_nxt;
			fast_r <= fast_nxt;
		end
	end

	assign gig_link_lamp = gig_r;
	assign fast_link_lamp = fast_r;

	no_link_dark_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!link_up |=> gig_link_lamp && fast_link_lamp)
		else $error("lamp lit without link");
endmodule
`default_nettype wire

// ===== core/pmw_magic.sv
// magic packet pattern matcher
`default_nettype none
module pmw_magic import pmw_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// received bytes
	pmw_rx_if.dst rx,
	// station address, first byte in bits 7:0
	input wire logic [47:0] station_addr,
	// one-cycle match at end of a good frame
	output logic hit
);
	pmw_mg_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic found_r, found_nxt, hit_r, hit_nxt;
	logic [7:0] exp_byte;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		idx_nxt = idx_r;
		found_nxt = found_r;
		hit_nxt = 1'b0;
		exp_byte = station_addr[8*idx_r +: 8];
		if (rx.byte_vld) begin
			unique case (st_r)
				MG_SYNC: begin
					if (rx.data != SYNC_BYTE) begin
						cnt_nxt = '0;
					end else if (cnt_r == 4'(SYNC_BYTES - 1)) begin
						st_nxt = MG_ADDR;
						cnt_nxt = '0;
						idx_nxt = '0;
					end else begin
						cnt_nxt = cnt_r + 1'b1;
					end
				end
				MG_ADDR: begin
					if (rx.data == exp_byte) begin
						idx_nxt = idx_r + 1'b1;
						if (idx_r == 3'(MAC_BYTES - 1)) begin
							idx_nxt = '0;
							cnt_nxt = cnt_r + 1'b1;
							if (cnt_r == 4'(ADDR_REPS - 1)) begin
								found_nxt = 1'b1;
								st_nxt = MG_SYNC;
								cnt_nxt = '0;
							end
						end
					end else if (!(idx_r == '0 && cnt_r == '0 && rx.data == SYNC_BYTE)) begin
						// a stray ones byte may open a new sync run
						st_nxt = MG_SYNC;
						idx_nxt = '0;
						cnt_nxt = {3'h0, rx.data == SYNC_BYTE};
					end
				end
			endcase
		end
		if (rx.frame_end) begin
			hit_nxt = found_r && !rx.frame_err;
			found_nxt = 1'b0;
			st_nxt = MG_SYNC;
			cnt_nxt = '0;
			idx_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= MG_SYNC;
			cnt_r <= '0;
			idx_r <= '0;
			found_r <= 1'b0;
			hit_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
			found_r <= found_nxt;
			hit_r <= hit_nxt;
		end
	end

	assign hit = hit_r;

	good_frame_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hit |-> $past(rx.frame_end) && !$past(rx.frame_err) && $past(found_r))
		else $error("magic hit without good frame end");
endmodule
`default_nettype wire

// ===== core/pmw_top.sv
// phy mode, loopback, power and wake control with axi4-lite registers
`default_nettype none
module pmw_top import pmw_pkg::*; #(
	parameter int BLINK_CYC = BLINK_CYC_DEF
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// straps
	input wire logic [3:0] mode_strap,
	input wire logic lamp_mode_strap,
	// phy core status
	input wire logic link_up,
	input wire logic [1:0] link_speed,
	input wire logic duplex_full,
	// mac transmit and receive side
	input wire logic mac_tx_clk,
	input wire logic [7:0] mac_txd,
	input wire logic mac_tx_en,
	output logic [7:0] mac_rxd,
	output logic mac_rx_dv,
	// line side
	input wire logic line_rx_clk,
	input wire logic [7:0] line_rxd,
	input wire logic line_rx_dv,
	input wire logic line_rx_er,
	output logic [7:0] line_txd,
	output logic line_tx_en,
	// power, test, lamps, wake
	output logic rx_power_on,
	output logic tx_power_on,
	output logic link_pulse_en,
	output logic test_chain_en,
	output logic gig_link_lamp,
	output logic fast_link_lamp,
	output logic wake_event_out_n
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// data rides the same two stages as its clock; the link clock is
	// eight system cycles long, so data is settled at the seen edge
	localparam int SW = 26;
	logic [SW-1:0] async_in, s1_r, s2_r;
	logic [3:0] strap_s;
	logic lamp_s, mclk_s, mten_s, lclk_s, ldv_s, ler_s;
	logic [7:0] mtxd_s, lrxd_s;

	assign async_in = {mode_strap, lamp_mode_strap, mac_tx_clk, mac_tx_en, mac_txd,
		line_rx_clk, line_rx_dv, line_rx_er, line_rxd};
	for (genvar i = 0; i < SW; i++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_r[i] <= 1'b0;
				s2_r[i] <= 1'b0;
			end else begin
				s1_r[i] <= async_in[i];
				s2_r[i] <= s1_r[i];
			end
		end
	end
	assign {strap_s, lamp_s, mclk_s, mten_s, mtxd_s, lclk_s, ldv_s, ler_s, lrxd_s} = s2_r;

	// ----------------------------------------
	// straps and modes
	// ----------------------------------------
	logic [3:0] mode_r, mode_nxt;
	logic [1:0] wait_r, wait_nxt;
	logic tri_r, tri_nxt, cap_r, cap_nxt;
	logic [5:0] ctrl_r, ctrl_nxt;
	logic normal_op, chip_powerdown, run, sleep, llb_act, rlb_act;

	always_comb begin
		mode_nxt = mode_r;
		tri_nxt = tri_r;
		cap_nxt = cap_r;
		wait_nxt = wait_r;
		if (!cap_r) begin
			wait_nxt = wait_r + 1'b1;
			if (wait_r == STRAP_WAIT) begin
				mode_nxt = strap_s;
				tri_nxt = !lamp_s;
				cap_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= MODE_RST;
			tri_r <= 1'b0;
			cap_r <= 1'b0;
			wait_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			tri_r <= tri_nxt;
			cap_r <= cap_nxt;
			wait_r <= wait_nxt;
		end
	end

	assign normal_op = cap_r && mode_r == MODE_NORMAL;
	assign chip_powerdown = cap_r && mode_r == MODE_CPD;
	assign test_chain_en = cap_r && mode_r == MODE_TEST;
	assign run = normal_op && !ctrl_r[CB_SPD];
	assign sleep = run && ctrl_r[CB_EDS] && ctrl_r[CB_ANE] && !link_up;
	assign rx_power_on = run && !sleep;
	assign tx_power_on = run;
	assign link_pulse_en = run && !link_up;
	assign llb_act = run && ctrl_r[CB_LLB] && duplex_full;
	assign rlb_act = run && ctrl_r[CB_RLB] && link_up && duplex_full && link_speed == SPD_1000;

	// ----------------------------------------
	// datapath and loopback
	// ----------------------------------------
	logic mclk_q_r, lclk_q_r, mten_r, ldv_r, ferr_r, mrise, lrise;
	logic [7:0] mtxd_r, lrxd_r, mrxd_r, ltxd_r;
	logic mrxdv_r, ltxen_r, activity;
	logic mten_nxt, ldv_nxt, ferr_nxt, mrxdv_nxt, ltxen_nxt;
	logic [7:0] mtxd_nxt, lrxd_nxt, mrxd_nxt, ltxd_nxt;
	pmw_rx_if rx_bus ();

	assign mrise = mclk_s && !mclk_q_r;
	assign lrise = lclk_s && !lclk_q_r;
	assign activity = run && ((mrise && mten_s && !mten_r) || (lrise && ldv_s && !ldv_r));
	assign rx_bus.byte_vld = run && lrise && ldv_s;
	assign rx_bus.data = lrxd_s;
	assign rx_bus.frame_end = lrise && !ldv_s && ldv_r;
	assign rx_bus.frame_err = ferr_r;

	always_comb begin
		mtxd_nxt = mrise ? mtxd_s : mtxd_r;
		mten_nxt = mrise ? mten_s : mten_r;
		lrxd_nxt = lrise ? lrxd_s : lrxd_r;
		ldv_nxt = lrise ? ldv_s : ldv_r;
		ferr_nxt = lrise ? (ldv_s && (ferr_r || ler_s)) : ferr_r;
		// power-down parks both directions at idle
		mrxd_nxt = '0;
		mrxdv_nxt = 1'b0;
		ltxd_nxt = '0;
		ltxen_nxt = 1'b0;
		if (run) begin
			mrxd_nxt = llb_act ? mtxd_r : lrxd_r;
			mrxdv_nxt = llb_act ? mten_r : ldv_r;
			ltxd_nxt = rlb_act ? lrxd_r : mtxd_r;
			ltxen_nxt = rlb_act ? ldv_r : mten_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mclk_q_r <= 1'b0;
			lclk_q_r <= 1'b0;
			mtxd_r <= '0;
			mten_r <= 1'b0;
			lrxd_r <= '0;
			ldv_r <= 1'b0;
			ferr_r <= 1'b0;
			mrxd_r <= '0;
			mrxdv_r <= 1'b0;
			ltxd_r <= '0;
			ltxen_r <= 1'b0;
		end else begin
			mclk_q_r <= mclk_s;
			lclk_q_r <= lclk_s;
			mtxd_r <= mtxd_nxt;
			mten_r <= mten_nxt;
			lrxd_r <= lrxd_nxt;
			ldv_r <= ldv_nxt;
			ferr_r <= ferr_nxt;
			mrxd_r <= mrxd_nxt;
			mrxdv_r <= mrxdv_nxt;
			ltxd_r <= ltxd_nxt;
			ltxen_r <= ltxen_nxt;
		end
	end

	assign mac_rxd = mrxd_r;
	assign mac_rx_dv = mrxdv_r;
	assign line_txd = ltxd_r;
	assign line_tx_en = ltxen_r;

	// ----------------------------------------
	// lamps and magic detection
	// ----------------------------------------
	logic [31:0] maclo_r, maclo_nxt;
	logic [15:0] machi_r, machi_nxt;
	logic mg_hit, wake_r, wake_nxt;

	pmw_lamp #(.BLINK_CYC(BLINK_CYC)) u_lamp (
		.aclk(aclk),
		.aresetn(aresetn),
		.tri_mode(tri_r),
		.link_up(run && link_up),
		.link_speed(link_speed),
		.activity(activity),
		.gig_link_lamp(gig_link_lamp),
		.fast_link_lamp(fast_link_lamp)
	);

	pmw_magic u_magic (
		.aclk(aclk),
		.aresetn(aresetn),
		.rx(rx_bus.dst),
		.station_addr({machi_r, maclo_r}),
		.hit(mg_hit)
	);

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [AW-1:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt, base, wm, rword;
	logic [3:0] ws_r, ws_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;

	assign awready = !aw_h_r && !bv_r;
	assign wready = !w_h_r && !bv_r;
	assign arready = !rv_r;

	always_comb begin
		aw_h_nxt = aw_h_r;
		awa_nxt = awa_r;
		w_h_nxt = w_h_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		bv_nxt = bv_r && !bready;
		br_nxt = br_r;
		rv_nxt = rv_r && !rready;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		ctrl_nxt = ctrl_r;
		maclo_nxt = maclo_r;
		machi_nxt = machi_r;
		base = '0;
		rword = '0;
		if (awvalid && awready) begin
			aw_h_nxt = 1'b1;
			awa_nxt = awaddr;
		end
		if (wvalid && wready) begin
			w_h_nxt = 1'b1;
			wd_nxt = wdata;
			ws_nxt = wstrb;
		end
		unique case (awa_r[AW-1:2])
			OFS_CTRL[AW-1:2]: base = {26'h0, ctrl_r};
			OFS_MACLO[AW-1:2]: base = maclo_r;
			OFS_MACHI[AW-1:2]: base = {16'h0, machi_r};
			default: base = '0;
		endcase
		for (int b = 0; b < 4; b++) begin
			wm[8*b +: 8] = ws_r[b] ? wd_r[8*b +: 8] : base[8*b +: 8];
		end
		if (aw_h_r && w_h_r) begin
			aw_h_nxt = 1'b0;
			w_h_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = RESP_OK;
			unique case (awa_r[AW-1:2])
				OFS_CTRL[AW-1:2]: ctrl_nxt = wm[5:0];
				OFS_MACLO[AW-1:2]: maclo_nxt = wm;
				OFS_MACHI[AW-1:2]: machi_nxt = wm[15:0];
				OFS_STAT[AW-1:2]: br_nxt = RESP_OK;
				default: br_nxt = RESP_ERR;
			endcase
		end
		if (arvalid && arready) begin
			rv_nxt = 1'b1;
			rr_nxt = RESP_OK;
			unique case (araddr[AW-1:2])
				OFS_CTRL[AW-1:2]: rword = {26'h0, ctrl_r};
				OFS_STAT[AW-1:2]: rword = {19'h0, wake_r, sleep, chip_powerdown, test_chain_en, tri_r,
					mode_r, duplex_full, link_speed, link_up};
				OFS_MACLO[AW-1:2]: rword = maclo_r;
				OFS_MACHI[AW-1:2]: rword = {16'h0, machi_r};
				default: rr_nxt = RESP_ERR;
			endcase
			rd_nxt = rword;
		end
		// leaving the enable low clears the wake; a hit in the same cycle only
		// counts while still enabled, so set and clear never fight
		wake_nxt = wake_r && ctrl_r[CB_MAG];
		if (mg_hit && ctrl_r[CB_MAG]) begin
			wake_nxt = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h_r <= 1'b0;
			awa_r <= '0;
			w_h_r <= 1'b0;
			wd_r <= '0;
			ws_r <= '0;
			bv_r <= 1'b0;
			br_r <= RESP_OK;
			rv_r <= 1'b0;
			rd_r <= '0;
			rr_r <= RESP_OK;
			ctrl_r <= CTRL_RST;
			maclo_r <= MACLO_RST;
			machi_r <= MACHI_RST;
			wake_r <= 1'b0;
		end else begin
			aw_h_r <= aw_h_nxt;
			awa_r <= awa_nxt;
			w_h_r <= w_h_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
			ctrl_r <= ctrl_nxt;
			maclo_r <= maclo_nxt;
			machi_r <= machi_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign bvalid = bv_r;
	assign bresp = br_r;
	assign rvalid = rv_r;
	assign rdata = rd_r;
	assign rresp = rr_r;
	assign wake_event_out_n = !wake_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	local_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		llb_act |=> mac_rxd == $past(mtxd_r) && mac_rx_dv == $past(mten_r))
		else $error("local loopback data not returned");
	remote_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(rlb_act) |-> line_txd == $past(lrxd_r) && $past(link_speed) == SPD_1000)
		else $error("remote loopback wrong");
	sleep_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sleep |-> !rx_power_on && tx_power_on && link_pulse_en && !link_up && ctrl_r[CB_ANE])
		else $error("sleep power state wrong");
	soft_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_r[CB_SPD] |-> !tx_power_on && !rx_power_on ##1 !line_tx_en && !mac_rx_dv)
		else $error("soft power-down left logic running");
	chip_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
		chip_powerdown |-> !tx_power_on && !rx_power_on ##1 chip_powerdown)
		else $error("chip power-down left early");
	reset_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(!aresetn) |-> !ctrl_r[CB_EDS] && !ctrl_r[CB_MAG] && wake_event_out_n)
		else $error("sleep or wake enabled after reset");
	wake_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mg_hit && ctrl_r[CB_MAG] |=> !wake_event_out_n)
		else $error("wake not driven on magic packet");
	wake_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!wake_event_out_n && ctrl_r[CB_MAG] |=> !wake_event_out_n)
		else $error("wake released while enabled");
	test_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
		test_chain_en |-> !run ##1 test_chain_en)
		else $error("test chain mode lost");
endmodule
`default_nettype wire

// ===== verification/pmw_link_model.sv
// link partner model: byte stream whose clock runs only within frames and for one idle edge after each
`default_nettype none
module pmw_link_model (
	// bench clock, only to keep link edges off its sampling edge
	input wire logic ref_clk,
	// link pins
	output logic clk_o,
	output logic [7:0] d_o,
	output logic dv_o,
	output logic er_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		clk_o = 0;
		d_o = 8'h00;
		dv_o = 0;
		er_o = 0;
	end
	// one idle edge closes the frame; released data shows the inverse, not a stale byte
	task automatic send(input logic [7:0] q[$], input int bad, input int half);
		@(negedge ref_clk);
		for (int i = 0; i <= q.size(); i++) begin
			dv_o = i < q.size();
			d_o = dv_o ? q[i] : ~d_o;
			er_o = i == bad;
			#half clk_o = 1;
			#half clk_o = 0;
		end
		er_o = 0;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the mode, loopback, power and wake block
`default_nettype none
module tb_top import pmw_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb, mode_strap;
	logic [31:0] wdata, rdata, rv;
	logic [1:0] bresp, rresp, rr, link_speed;
	logic lamp_mode_strap, link_up, duplex_full, mac_tx_clk, mac_tx_en, line_rx_clk, line_rx_dv, line_rx_er;
	logic [7:0] mac_txd, line_rxd, mac_rxd, line_txd, pd, cd;
	logic mac_rx_dv, line_tx_en, rx_power_on, tx_power_on, link_pulse_en, test_chain_en;
	logic gig_link_lamp, fast_link_lamp, wake_event_out_n, cap_line, pv, cv;
	logic [7:0] got[$];
	int errors, n_checks;
	pmw_top #(.BLINK_CYC(4)) pmw_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.mode_strap, .lamp_mode_strap, .link_up, .link_speed, .duplex_full, .mac_tx_clk, .mac_txd, .mac_tx_en,
		.mac_rxd, .mac_rx_dv, .line_rx_clk, .line_rxd, .line_rx_dv, .line_rx_er, .line_txd, .line_tx_en,
		.rx_power_on, .tx_power_on, .link_pulse_en, .test_chain_en, .gig_link_lamp, .fast_link_lamp,
		.wake_event_out_n);
	pmw_link_model pmw_link_model_mac_i (.ref_clk(aclk), .clk_o(mac_tx_clk), .d_o(mac_txd), .dv_o(mac_tx_en),
		.er_o());
	pmw_link_model pmw_link_model_line_i (.ref_clk(aclk), .clk_o(line_rx_clk), .d_o(line_rxd),
		.dv_o(line_rx_dv), .er_o(line_rx_er));
	assign cv = cap_line ? line_tx_en : mac_rx_dv;
	assign cd = cap_line ? line_txd : mac_rxd;
	// bytes held for several cycles: a new byte is a change, so test frames avoid repeats
	always @(negedge aclk) begin
		if (cv && (!pv || cd !== pd))
			got.push_back(cd);
		pv <= cv;
		pd <= cd;
	end
	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	// ----------------------------------------
	// common tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		if (errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic tmo;
		errors++;
		$display("BAD %0t timeout", $time);
		tally_and_finish();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic rst(input logic [3:0] m);
		mode_strap <= m;
		aresetn <= 0;
		tick(12);
		aresetn <= 1;
		tick(6);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int k = 0;
		bit ah = 0;
		bit wh = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			k++;
			if (awready)
				ah = 1;
			if (wready)
				wh = 1;
			if (ah)
				awvalid <= 0;
			if (wh)
				wvalid <= 0;
		end while (!(ah && wh) && k < 50);
		do begin
			@(posedge aclk);
			k++;
		end while (!bvalid && k < 100);
		bready <= 0;
		chk(bresp === RESP_OK, "bresp");
		if (k >= 100)
			tmo();
	endtask
	task automatic rd(input logic [3:0] a);
		int k = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			k++;
		end while (!arready && k < 50);
		arvalid <= 0;
		do begin
			@(posedge aclk);
			k++;
		end while (!rvalid && k < 100);
		rready <= 0;
		rv = rdata;
		rr = rresp;
		if (k >= 100)
			tmo();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(OFS_CTRL);
		chk(rv === {26'h000_0000, CTRL_RST}, "ctrl reset");
		rd(OFS_STAT);
		chk(rv[7:4] === MODE_NORMAL && rv[8] === 1, "stat reset");
		chk(wake_event_out_n === 1 && gig_link_lamp === 1 && fast_link_lamp === 1, "idle outs");
		chk(tx_power_on === 1 && test_chain_en === 0, "normal mode");
	endtask
	task automatic t_lamps;
		logic [7:0] q[$] = '{8'h11, 8'h22, 8'h33};
		int tg = 0;
		logic g = 0;
		link_up <= 1;
		for (int s = 0; s < 3; s++) begin
			link_speed <= s[1:0];
			tick(4);
			chk(gig_link_lamp === (s == 1) && fast_link_lamp === (s == 2), "speed lamps");
		end
		fork
			pmw_link_model_line_i.send(q, -1, 400);
			for (int i = 0; i < 60; i++) begin
				@(negedge aclk);
				if (gig_link_lamp !== g)
					tg++;
				g = gig_link_lamp;
			end
		join
		chk(tg >= 2, "blink");
		chk(got == q, "line to mac");
		tick(20);
		chk(gig_link_lamp === 0, "blink ends");
		link_up <= 0;
		tick(4);
		chk(gig_link_lamp === 1 && fast_link_lamp === 1, "no link");
	endtask
	task automatic t_loop;
		logic [7:0] q[$] = '{8'h5d, 8'h01, 8'ha2, 8'h3c};
		link_up <= 1;
		duplex_full <= 1;
		cap_line = 0;
		for (int s = 0; s < 4; s++) begin
			if (s == 3)
				duplex_full <= 0;
			link_speed <= s == 3 ? SPD_100 : s[1:0];
			wr(OFS_CTRL, 32'h0000_0001);
			got.delete();
			pmw_link_model_mac_i.send(q, -1, 400);
			tick(12);
			if (s < 3)
				chk(got == q, "local loop");
			else
				chk(got.size() == 0, "half duplex");
		end
	endtask
	task automatic t_remote;
		logic [7:0] q[$] = '{8'h71, 8'h82, 8'h93};
		duplex_full <= 1;
		link_speed <= SPD_1000;
		wr(OFS_CTRL, 32'h0000_0012);
		cap_line = 1;
		for (int s = 0; s < 2; s++) begin
			if (s == 1)
				link_speed <= SPD_100;
			tick(2);
			got.delete();
			pmw_link_model_line_i.send(q, -1, 400);
			tick(12);
			chk(s == 0 ? got == q : got.size() == 0, "remote loop");
		end
		wr(OFS_CTRL, 32'h0000_0010);
	endtask
	task automatic t_power;
		wr(OFS_CTRL, 32'h0000_0014);
		tick(3);
		chk(!rx_power_on && !tx_power_on, "powered down");
		rd(OFS_STAT);
		chk(rr === RESP_OK && rv[0] === 1, "mgmt alive");
		wr(OFS_CTRL, 32'h0000_0010);
		tick(3);
		chk(rx_power_on && tx_power_on, "resumed");
		link_up <= 0;
		wr(OFS_CTRL, 32'h0000_0018);
		tick(3);
		chk(!rx_power_on && tx_power_on && link_pulse_en, "sleep");
		link_up <= 1;
		tick(4);
		chk(rx_power_on, "linked awake");
		link_up <= 0;
		wr(OFS_CTRL, 32'h0000_0008);
		tick(3);
		chk(rx_power_on, "no autoneg awake");
		link_up <= 1;
		wr(OFS_CTRL, 32'h0000_0010);
	endtask
	task automatic t_magic;
		logic [7:0] sa[6] = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		logic [7:0] q[$] = '{8'h00, 8'hff, 8'hff, 8'h02, 8'h07};
		logic [7:0] f[$];
		int k;
		wr(OFS_MACLO, 32'h3322_1102);
		wr(OFS_MACHI, 32'h0000_5544);
		repeat (6) q.push_back(8'hff);
		repeat (16) foreach (sa[j]) q.push_back(sa[j]);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL, c == 0 ? 32'h0000_0010 : 32'h0000_0030);
			f = q;
			if (c == 1)
				f[40] = 8'h5a;
			pmw_link_model_line_i.send(f, c == 2 ? 30 : -1, 400);
			k = 0;
			while (wake_event_out_n !== 0 && k < 40) begin
				@(posedge aclk);
				k++;
			end
			chk(wake_event_out_n === (c != 3), "wake");
		end
		tick(50);
		chk(wake_event_out_n === 0, "wake held");
		wr(OFS_CTRL, 32'h0000_0010);
		tick(3);
		chk(wake_event_out_n === 1, "wake cleared");
	endtask
	task automatic t_strap;
		rst(MODE_TEST);
		chk(test_chain_en === 1 && tx_power_on === 0, "test chain");
		lamp_mode_strap <= 1;
		rst(MODE_CPD);
		wr(OFS_CTRL, 32'h0000_0014);
		wr(OFS_CTRL, 32'h0000_0010);
		rd(OFS_STAT);
		chk(rv[10] === 1 && rv[8] === 0 && tx_power_on === 0, "chip down");
		lamp_mode_strap <= 0;
		rst(MODE_NORMAL);
		rd(OFS_STAT);
		chk(rv[10] === 0 && rv[8] === 1 && tx_power_on === 1, "chip up");
	endtask
	initial begin
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready, link_up, duplex_full, lamp_mode_strap, cap_line} = '0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0000_0000;
		wstrb = 4'hf;
		link_speed = SPD_10;
		mode_strap = MODE_NORMAL;
		rst(MODE_NORMAL);
		t_reset();
		t_lamps();
		t_loop();
		t_remote();
		t_power();
		t_magic();
		t_strap();
		tally_and_finish();
	end
endmodule
`default_nettype wire
